// [src/boisa_pkg.sv]
// package: opcode selection, widths and reset values for the byte alu datapath
package boisa_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic       ZERO_RST  = 1'b0;
  localparam logic       CARRY_RST = 1'b0;
  localparam logic       TGT_ACC   = 1'b0;
  localparam logic       TGT_FILE  = 1'b1;
  localparam int SHIFT_MSB = 7;
  localparam int SHIFT_LSB = 0;
  localparam logic [6:0] WADDR_RST = 7'h00;
  localparam logic [7:0] WDATA_RST = 8'h00;
  localparam logic [7:0] INC_STEP  = 8'h01;

  typedef enum logic [2:0] {
    BOISA_NOP_OP,
    BOISA_OR_IMMEDIATE_OP,
    BOISA_INCREMENT_OP,
    BOISA_OR_REGISTER_OP,
    BOISA_SHIFT_UP_OP,
    BOISA_SHIFT_DOWN_OP,
    BOISA_COPY_REGISTER_OP
  } boisa_op_t;
endpackage

// [src/boisa_alu.sv]
// module: single-cycle byte alu for or, increment, shift and copy operations
`timescale 1ns/10ps
// Contract
// - or-immediate ors the accumulator with an 8-bit literal into the accumulator, only zero changes.
// - with target select 0 the result goes to the accumulator and the file register is not written.
// - with target select 1 the result of every op except nop and or-immediate is written back to the file register at address 0 to 127.
// - increment adds one to the file register value, sends it to the target, only zero changes.
// - or-register ors accumulator with the file register, sends it to the target, only zero changes.
// - shift-up moves bit 7 to carry, bits 6..0 up to 7..1, and puts zero in bit 0.
// - shift-down puts zero in bit 7, moves bits 7..1 down to 6..0, and bit 0 to carry.
// - both shifts update carry and zero and send the shifted byte to the selected target.
// - copy-register passes the file value unchanged to the target and updates zero.
module boisa_alu
  import boisa_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire boisa_op_t         opSel,
  input  wire logic              targetSel,
  input  wire logic [DATA_W-1:0] literal,
  input  wire logic [ADDR_W-1:0] fileAddr,
  input  wire logic [DATA_W-1:0] fileRdata,
  output logic [DATA_W-1:0]      acc,
  output logic                   zeroFlag,
  output logic                   carryFlag,
  output logic                   fileWe,
  output logic [ADDR_W-1:0]      fileWaddr,
  output logic [DATA_W-1:0]      fileWdata
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic isZero(input logic [DATA_W-1:0] v);
    return (v == '0);
  endfunction

  function automatic logic isActiveOp(input boisa_op_t op);
    return (op != BOISA_NOP_OP);
  endfunction

  // operations that read the file and honour the target select
  function automatic logic isRegOp(input boisa_op_t op);
    logic hit;
    case (op)
      BOISA_INCREMENT_OP:     hit = 1'b1;
      BOISA_OR_REGISTER_OP:   hit = 1'b1;
      BOISA_SHIFT_UP_OP:      hit = 1'b1;
      BOISA_SHIFT_DOWN_OP:    hit = 1'b1;
      BOISA_COPY_REGISTER_OP: hit = 1'b1;
      default:                hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic isShiftOp(input boisa_op_t op);
    logic hit;
    case (op)
      BOISA_SHIFT_UP_OP:   hit = 1'b1;
      BOISA_SHIFT_DOWN_OP: hit = 1'b1;
      default:             hit = 1'b0;
    endcase
    return hit;
  endfunction

  // or of the accumulator with either operand
  function automatic logic [DATA_W-1:0] orBytes(
    input logic [DATA_W-1:0] a,
    input logic [DATA_W-1:0] b
  );
    return a | b;
  endfunction

  // zero enters at the bottom, the top bit leaves for the carry
  function automatic logic [DATA_W-1:0] shiftUp(input logic [DATA_W-1:0] v);
    return {v[SHIFT_MSB-1:SHIFT_LSB], 1'b0};
  endfunction

  // zero enters at the top, the bottom bit leaves for the carry
  function automatic logic [DATA_W-1:0] shiftDown(input logic [DATA_W-1:0] v);
    return {1'b0, v[SHIFT_MSB:SHIFT_LSB+1]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state and next values
  logic [DATA_W-1:0] acc_r;
  logic [DATA_W-1:0] acc_nxt;
  logic              zero_r;
  logic              zero_nxt;
  logic              carry_r;
  logic              carry_nxt;
  logic              fileWe_r;
  logic              fileWe_nxt;
  logic [ADDR_W-1:0] fileWaddr_r;
  logic [ADDR_W-1:0] fileWaddr_nxt;
  logic [DATA_W-1:0] fileWdata_r;
  logic [DATA_W-1:0] fileWdata_nxt;

  // shared datapath
  logic [DATA_W-1:0] result;
  logic              shiftCarry;
  logic              opActive;
  logic              toFile;

  ////////////////////////////////////////////////////////////////////////////
  // operand selection and result
  // unused codes fall to the plain copy path
  always_comb begin
    result     = fileRdata;
    shiftCarry = carry_r;
    case (opSel)
      BOISA_OR_IMMEDIATE_OP: begin
        result = orBytes(acc_r, literal);
      end
      BOISA_INCREMENT_OP: begin
        result = fileRdata + INC_STEP;
      end
      BOISA_OR_REGISTER_OP: begin
        result = orBytes(acc_r, fileRdata);
      end
      BOISA_SHIFT_UP_OP: begin
        result     = shiftUp(fileRdata);
        shiftCarry = fileRdata[SHIFT_MSB];
      end
      BOISA_SHIFT_DOWN_OP: begin
        result     = shiftDown(fileRdata);
        shiftCarry = fileRdata[SHIFT_LSB];
      end
      BOISA_COPY_REGISTER_OP: begin
        result = fileRdata;
      end
      default: begin
        result = fileRdata;
      end
    endcase
  end

  // or-immediate always lands in the accumulator, whatever the target select says
  always_comb begin
    opActive = isActiveOp(opSel);
    toFile   = 1'b0;
    if (opActive && isRegOp(opSel) && (targetSel == TGT_FILE)) begin
      toFile = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator
  always_comb begin
    acc_nxt = acc_r;
    if (opActive && !toFile) begin
      acc_nxt = result;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      acc_r <= ACC_RST;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags
  always_comb begin
    zero_nxt  = zero_r;
    carry_nxt = carry_r;
    if (opActive) begin
      zero_nxt = isZero(result);
      if (isShiftOp(opSel)) begin
        carry_nxt = shiftCarry;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      zero_r  <= ZERO_RST;
      carry_r <= CARRY_RST;
    end else begin
      zero_r  <= zero_nxt;
      carry_r <= carry_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // file register write port
  // address and data hold between writes, the strobe lasts one cycle
  always_comb begin
    fileWe_nxt    = 1'b0;
    fileWaddr_nxt = fileWaddr_r;
    fileWdata_nxt = fileWdata_r;
    if (toFile) begin
      fileWe_nxt    = 1'b1;
      fileWaddr_nxt = fileAddr;
      fileWdata_nxt = result;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fileWe_r    <= 1'b0;
      fileWaddr_r <= WADDR_RST;
      fileWdata_r <= WDATA_RST;
    end else begin
      fileWe_r    <= fileWe_nxt;
      fileWaddr_r <= fileWaddr_nxt;
      fileWdata_r <= fileWdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the registers
  assign acc       = acc_r;
  assign zeroFlag  = zero_r;
  assign carryFlag = carry_r;
  assign fileWe    = fileWe_r;
  assign fileWaddr = fileWaddr_r;
  assign fileWdata = fileWdata_r;

endmodule

// [verif/boisa_alu_monitor.sv]
// checker: datapath timing and result relations
`timescale 1ns/10ps
module boisa_alu_monitor
  import boisa_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire boisa_op_t   opSel,
  input wire logic        targetSel,
  input wire logic [7:0]  literal,
  input wire logic [6:0]  fileAddr,
  input wire logic [7:0]  fileRdata,
  input wire logic [7:0]  acc,
  input wire logic        zeroFlag,
  input wire logic        carryFlag,
  input wire logic        fileWe,
  input wire logic [6:0]  fileWaddr,
  input wire logic [7:0]  fileWdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic wrReq;
  assign wrReq = opSel != BOISA_NOP_OP && opSel != BOISA_OR_IMMEDIATE_OP && targetSel;
  sequence s_fwr;
    fileWe && fileWaddr == $past(fileAddr);
  endsequence
  a_ori_zero:
    assert property (opSel == BOISA_OR_IMMEDIATE_OP |=> !fileWe && zeroFlag == (acc == 0)
      && acc == ($past(acc) | $past(literal))) else $error("or literal result");
  a_acc_route:
    assert property (opSel != BOISA_NOP_OP && !targetSel |=> !fileWe) else $error("acc route");
  a_file_route:
    assert property (wrReq |=> s_fwr ##1 (fileWe == $past(wrReq))) else $error("file route");
  a_inc_sum:
    assert property (opSel == BOISA_INCREMENT_OP && targetSel
      |=> fileWdata == $past(fileRdata) + 8'h01) else $error("inc data");
  a_orr_data:
    assert property (opSel == BOISA_OR_REGISTER_OP && targetSel
      |=> fileWdata == ($past(fileRdata) | acc)) else $error("or data");
  a_shl_carry:
    assert property (opSel == BOISA_SHIFT_UP_OP |=> carryFlag == $past(fileRdata[7])
      && zeroFlag == ($past(fileRdata[6:0]) == 0)) else $error("shift up");
  a_shr_carry:
    assert property (opSel == BOISA_SHIFT_DOWN_OP |=> carryFlag == $past(fileRdata[0]))
    else $error("shift down");
  a_copy_zero:
    assert property (opSel == BOISA_COPY_REGISTER_OP |=> zeroFlag == ($past(fileRdata) == 0))
    else $error("copy zero");
  a_carry_keep:
    assert property (opSel != BOISA_SHIFT_UP_OP && opSel != BOISA_SHIFT_DOWN_OP
      |=> $stable(carryFlag)) else $error("carry kept");
  a_shift_wdata:
    assert property (opSel == BOISA_SHIFT_UP_OP && targetSel
      |=> fileWdata == {$past(fileRdata[6:0]), 1'b0}) else $error("shift up data");
  a_shift_acc:
    assert property (opSel == BOISA_SHIFT_DOWN_OP && !targetSel
      |=> acc == {1'b0, $past(fileRdata[7:1])}) else $error("shift down data");
  a_zero_acc:
    assert property (opSel != BOISA_NOP_OP && !targetSel |=> zeroFlag == (acc == 0))
    else $error("zero from acc");
  a_nop_hold:
    assert property (opSel == BOISA_NOP_OP |=> $stable(acc) && $stable(zeroFlag) && !fileWe)
    else $error("idle changed state");
endmodule
bind boisa_alu boisa_alu_monitor mon_u (
  .mclk(mclk), .rst_n(rst_n), .opSel(opSel), .targetSel(targetSel), .literal(literal),
  .fileAddr(fileAddr), .fileRdata(fileRdata), .acc(acc), .zeroFlag(zeroFlag),
  .carryFlag(carryFlag), .fileWe(fileWe), .fileWaddr(fileWaddr), .fileWdata(fileWdata));

// [verif/boisa_file_model.sv]
// partner: file register space with write forwarding
`timescale 1ns/10ps
module boisa_file_model
  import boisa_pkg::*;
(
  input wire logic        mclk,
  input wire logic [6:0]  rdAddr,
  input wire logic        we,
  input wire logic [6:0]  wAddr,
  input wire logic [7:0]  wData,
  output logic [7:0]      rData
);
  logic [7:0] mem [128];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
  always @(posedge mclk) if (we) mem[wAddr] <= wData;
  assign rData = (we && wAddr == rdAddr) ? wData : mem[rdAddr];
endmodule

// [verif/test_byte_or_inc_shift_move_alu.sv]
// testbench: random op stream against a behavioural model
`timescale 1ns/10ps
module test_byte_or_inc_shift_move_alu;
  import boisa_pkg::*;
  logic mclk = 0, rst_n = 0, targetSel = 0, fileWe, zeroFlag, carryFlag;
  boisa_op_t opSel = BOISA_NOP_OP;
  logic [7:0] literal = 0, acc, fileWdata, fileRdata;
  logic [6:0] fileAddr = 0, fileWaddr;
  int n_errors = 0, samples_checked = 0, seed = 80, ea = 0, ez = 0, ec = 0, ew = 0, ed, r, f, v;
  int wa = 0;
  int em[128];
  always #12.5 mclk = ~mclk;
  boisa_alu dut_u (.mclk(mclk), .rst_n(rst_n), .opSel(opSel), .targetSel(targetSel),
    .literal(literal), .fileAddr(fileAddr), .fileRdata(fileRdata), .acc(acc),
    .zeroFlag(zeroFlag), .carryFlag(carryFlag), .fileWe(fileWe), .fileWaddr(fileWaddr),
    .fileWdata(fileWdata));
  boisa_file_model file_u (.mclk(mclk), .rdAddr(fileAddr), .we(fileWe), .wAddr(fileWaddr),
    .wData(fileWdata), .rData(fileRdata));
  task chk(input logic [7:0] g, input int e);
    samples_checked++;
    if (g !== 8'(e)) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, 8'(e));
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 128; i++) em[i] = (i * 37) % 256;
    repeat (6) @(posedge mclk);
    #1 rst_n = 1;
    for (int k = 0; k < 2000; k++) begin
      @(posedge mclk);
      #1;
      chk(acc, ea);
      chk({zeroFlag, carryFlag, fileWe}, ez * 4 + ec * 2 + ew);
      if (ew) begin
        chk(fileWdata, ed);
        chk({1'b0, fileWaddr}, wa);
      end
      if (k == 1000) begin
        $display("test stream_a done checks %0d", samples_checked);
        rst_n = 0;
        opSel = BOISA_NOP_OP;
        @(posedge mclk);
        #1;
        rst_n = 1;
        ea = 0;
        ez = 0;
        ec = 0;
        ew = 0;
        chk(acc, 0);
        chk({zeroFlag, carryFlag, fileWe}, 0);
        chk(fileWdata, 0);
        chk({1'b0, fileWaddr}, 0);
      end
      r = $random(seed);
      opSel = boisa_op_t'((r & 255) % 7);
      targetSel = r[3];
      literal = r[15:8];
      fileAddr = r[22:16];
      f = em[fileAddr];
      ew = 0;
      case (opSel)
        BOISA_OR_IMMEDIATE_OP: v = ea | literal;
        BOISA_INCREMENT_OP: v = (f + 1) % 256;
        BOISA_OR_REGISTER_OP: v = ea | f;
        BOISA_SHIFT_UP_OP: begin
          ec = f >> 7;
          v = (f << 1) % 256;
        end
        BOISA_SHIFT_DOWN_OP: begin
          ec = f & 1;
          v = f >> 1;
        end
        default: v = f;
      endcase
      if (opSel != BOISA_NOP_OP) begin
        ez = (v == 0);
        if (targetSel && opSel != BOISA_OR_IMMEDIATE_OP) begin
          ew = 1;
          em[fileAddr] = v;
          ed = v;
          wa = fileAddr;
        end else ea = v;
      end
    end
    $display("test stream_b done checks %0d", samples_checked);
    wrap_up;
  end
  initial begin
    #75000;
    n_errors++;
    wrap_up;
  end
endmodule
